// >>> src/mzs_pkg.sv
package mzs_pkg;

    // Time base.
    localparam int CLK_HZ        = 25_000_000;
    localparam int TIME_UNIT_HZ  = 1000;
    localparam int CYC_PER_MS    = CLK_HZ / TIME_UNIT_HZ;

    // Documented times, each in its own unit.
    localparam int WIN_STEP_MS   = 30;
    localparam int PAIR_WAIT_S   = 4;
    localparam int PAIR_WAIT_MS  = PAIR_WAIT_S * 1000;
    localparam int MUTE_LIMIT_MIN = 10;
    localparam int MUTE_LIMIT_S  = MUTE_LIMIT_MIN * 60;
    localparam int FLASH_HZ      = 1;
    localparam int FLASH_HALF_MS = 1000 / (2 * FLASH_HZ);
    localparam int MS_PER_S      = 1000;

    // Register offsets (byte addresses).
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LIMIT  = 8'h04;
    localparam logic [7:0] ADDR_STATE  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h10;

    // Control register fields.
    localparam int CTRL_WIN_LSB   = 0;
    localparam int CTRL_WIN_W     = 5;
    localparam int CTRL_UNLIM_BIT = 8;
    localparam int CTRL_DUST_LSB  = 12;
    localparam int LIMIT_W        = 16;

    // Reset values.
    localparam logic [4:0]  WIN_STEPS_RST = 5'h01;
    localparam logic [15:0] LIMIT_RST     = 16'(MUTE_LIMIT_S);

    // Dust filter levels.
    typedef enum logic [1:0] {
        DUST_LOW  = 2'h0,
        DUST_AVG  = 2'h1,
        DUST_HIGH = 2'h2
    } mzs_dust_t;

    typedef struct packed {
        logic [4:0] winSteps;
        logic       unlimited;
        mzs_dust_t  dust;
    } mzs_cfg_t;

    // Interrupt event bits.
    localparam int IRQ_W          = 5;
    localparam int EV_MUTE_START  = 0;
    localparam int EV_MUTE_END    = 1;
    localparam int EV_MUTE_CANCEL = 2;
    localparam int EV_ZONE_FAULT  = 3;
    localparam int EV_ZONE_CHANGE = 4;

    typedef struct packed {
        logic [3:0] zoneSet;
        logic       zoneFault;
        logic       muted;
        logic       cancelled;
        logic       winRunning;
    } mzs_stat_t;

endpackage

// >>> src/mzs_tick.sv
`timescale 1ns/10ps
`default_nettype none

// Millisecond time base and the muting lamp flash pattern.
module mzs_tick #(
    parameter int CYC_PER_MS = mzs_pkg::CYC_PER_MS,
    parameter int HALF_MS    = mzs_pkg::FLASH_HALF_MS
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Time base
    output logic      msTick,
    output logic      flash
);

    logic [$clog2(CYC_PER_MS)-1:0] cycCnt;
    logic [$clog2(HALF_MS+1)-1:0]  msCnt;
    wire                           cycWrap = (cycCnt == ($bits(cycCnt))'(CYC_PER_MS - 1));
    wire                           msWrap  = (msCnt == ($bits(msCnt))'(HALF_MS - 1));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cycCnt <= '0;
            msCnt  <= '0;
            msTick <= 1'b0;
            flash  <= 1'b0;
        end else begin
            msTick <= cycWrap;
            cycCnt <= cycWrap ? '0 : cycCnt + 1'b1;
            if (cycWrap) begin
                msCnt <= msWrap ? '0 : msCnt + 1'b1;
                if (msWrap) begin
                    flash <= ~flash;
                end
            end
        end
    end

endmodule // mzs_tick

`default_nettype wire

// >>> src/mzs_muting_zone.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Bad zone codes are ignored while the switchover window runs.
// - Switchover window is programmed in 30 ms steps.
// - Muting starts when both sensors agree, or second follows within 4 s.
// - Muting timer runs; on expiry with sensors active, muting cancels, outputs go safe.
// - Muting limit is programmable; unlimited ends only when sensors clear.
// - No muting start while an object sits in the safety zone.
// - Lamp flashes only during muting, dark while waiting for the second sensor.
// - Material leaving first output-side sensor ends muting and darkens lamp.
// - Dust filter sensitivity offers high, average and low levels.
// - Zone violation or cancelled muting drops the safety output pair.
module mzs_muting_zone #(
    parameter int CYC_PER_MS = mzs_pkg::CYC_PER_MS,
    parameter int ZONE_SETS  = 10
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    // Machine controller and sensors
    input  wire logic [3:0]  zoneCode,
    input  wire logic        muteSensA,
    input  wire logic        muteSensB,
    input  wire logic        muteSensOut,
    input  wire logic        objectInZone,
    // Outputs
    output logic      [3:0]  activeZone,
    output logic      [1:0]  safetySwitchOutputPair,
    output logic             muteLamp,
    output logic      [1:0]  dustLevel,
    output logic             irq
);

    typedef enum logic [2:0] {
        MS_IDLE,
        MS_WAIT2,
        MS_MUTED,
        MS_CANCEL,
        MS_REARM
    } mzs_mstate_t;

    // Configuration and interrupt registers.
    mzs_pkg::mzs_cfg_t         cfg;
    logic [15:0]               limitS;
    logic [mzs_pkg::IRQ_W-1:0] irqStat;
    logic [mzs_pkg::IRQ_W-1:0] irqMask;

    // Zone selection state.
    logic [3:0]  zoneSet;
    logic [3:0]  zonePrev;
    logic [15:0] winLeft;
    logic        zoneFault;

    // Muting state.
    mzs_mstate_t mst;
    mzs_mstate_t next_mst;
    logic [12:0] pairMs;
    logic [9:0]  msInSec;
    logic [15:0] muteSec;
    logic        outSeen;

    logic msTick;
    logic flash;

    mzs_tick #(
        .CYC_PER_MS (CYC_PER_MS),
        .HALF_MS    (mzs_pkg::FLASH_HALF_MS)
    ) u_tick (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .msTick   (msTick),
        .flash    (flash)
    );

    // Codes at or above the number of zone sets select nothing and count as invalid.
    function automatic logic zoneValid(input logic [3:0] code);
        return (code < 4'(ZONE_SETS));
    endfunction

    // Register decode.
    wire wrCtrl  = regWr && (regAddr == mzs_pkg::ADDR_CTRL);
    wire wrLimit = regWr && (regAddr == mzs_pkg::ADDR_LIMIT);
    wire wrIrqSt = regWr && (regAddr == mzs_pkg::ADDR_IRQ_ST);
    wire wrIrqMk = regWr && (regAddr == mzs_pkg::ADDR_IRQ_MK);
    wire [1:0] wrDust = regWdata[mzs_pkg::CTRL_DUST_LSB +: 2];
    wire       dustOk = (wrDust != 2'h3);

    // Zone selection decode.
    wire codeChanged = (zoneCode != zonePrev);
    wire winRunning  = (winLeft != 16'h0000);
    wire codeOk      = zoneValid(zoneCode);
    wire next_fault  = !codeOk && !winRunning && !codeChanged;
    // A zero step count gives no window, so a bad code faults on the second edge after it appears.
    wire [15:0] winLoad = 16'(cfg.winSteps) * 16'(mzs_pkg::WIN_STEP_MS);

    // Muting decode.
    wire anySens   = muteSensA || muteSensB;
    wire bothSens  = muteSensA && muteSensB;
    wire pairLate  = (pairMs >= 13'(mzs_pkg::PAIR_WAIT_MS));
    wire limitHit  = !cfg.unlimited && (muteSec >= limitS);
    wire allClear  = !anySens && !muteSensOut;
    wire outCleared = outSeen && !muteSensOut;
    wire muted     = (mst == MS_MUTED);
    wire inCancel  = (mst == MS_CANCEL);
    wire secWrap   = msTick && (msInSec == 10'(mzs_pkg::MS_PER_S - 1));

    always_comb begin
        next_mst = mst;
        case (mst)
            MS_IDLE: begin
                if (bothSens && !objectInZone) begin
                    next_mst = MS_MUTED;
                end else if (anySens) begin
                    next_mst = MS_WAIT2;
                end
            end
            MS_WAIT2: begin
                if (bothSens && !objectInZone && !pairLate) begin
                    next_mst = MS_MUTED;
                end else if (pairLate || objectInZone) begin
                    next_mst = MS_REARM;
                end else if (!anySens) begin
                    next_mst = MS_IDLE;
                end
            end
            MS_MUTED: begin
                if (limitHit && (anySens || muteSensOut)) begin
                    next_mst = MS_CANCEL;
                end else if (outCleared || allClear) begin
                    next_mst = MS_IDLE;
                end
            end
            // The pair stays safe here until every sensor has cleared, so no restart slips in.
            MS_CANCEL: begin
                if (allClear) begin
                    next_mst = MS_IDLE;
                end
            end
            MS_REARM: begin
                // A late or refused sequence must clear before a new one may start.
                if (!anySens) begin
                    next_mst = MS_IDLE;
                end
            end
            default: next_mst = MS_IDLE;
        endcase
    end

    // Events for the interrupt status register.
    // Events are taken from the next state, so each one is flagged in exactly one cycle.
    logic [mzs_pkg::IRQ_W-1:0] events;
    always_comb begin
        events = '0;
        events[mzs_pkg::EV_MUTE_START]  = !muted && (next_mst == MS_MUTED);
        events[mzs_pkg::EV_MUTE_END]    = muted && (next_mst == MS_IDLE);
        events[mzs_pkg::EV_MUTE_CANCEL] = muted && (next_mst == MS_CANCEL);
        events[mzs_pkg::EV_ZONE_FAULT]  = next_fault && !zoneFault;
        events[mzs_pkg::EV_ZONE_CHANGE] = codeOk && (zoneCode != zoneSet);
    end

    // Safety decision: a muted zone violation is tolerated, anything else drops the pair.
    wire violation = objectInZone && !muted;
    // The pair is registered, so a violation drops it on the same edge that samples it.
    wire pairOn    = !violation && !zoneFault && !inCancel;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg       <= '{winSteps: mzs_pkg::WIN_STEPS_RST, unlimited: 1'b0,
                           dust: mzs_pkg::DUST_AVG};
            limitS    <= mzs_pkg::LIMIT_RST;
            irqMask   <= '0;
        end else begin
            if (wrCtrl) begin
                cfg.winSteps  <= regWdata[mzs_pkg::CTRL_WIN_LSB +: mzs_pkg::CTRL_WIN_W];
                cfg.unlimited <= regWdata[mzs_pkg::CTRL_UNLIM_BIT];
                if (dustOk) begin
                    cfg.dust <= mzs_pkg::mzs_dust_t'(wrDust);
                end
            end
            if (wrLimit) begin
                limitS <= regWdata[mzs_pkg::LIMIT_W-1:0];
            end
            if (wrIrqMk) begin
                irqMask <= regWdata[mzs_pkg::IRQ_W-1:0];
            end
        end
    end

    // Sticky status: a new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqStat <= '0;
        end else begin
            irqStat <= (irqStat & ~(wrIrqSt ? regWdata[mzs_pkg::IRQ_W-1:0] : '0)) | events;
        end
    end

    // Zone selection with switchover window.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            zoneSet   <= '0;
            zonePrev  <= '0;
            winLeft   <= '0;
            zoneFault <= 1'b0;
        end else begin
            zonePrev <= zoneCode;
            if (codeChanged) begin
                winLeft <= winLoad;
            end else if (msTick && winRunning) begin
                winLeft <= winLeft - 16'h0001;
            end
            if (codeOk) begin
                zoneSet <= zoneCode;
            end
            zoneFault <= next_fault;
        end
    end

    // Muting sequencer and its timers.
    // The second counter saturates, so a long unlimited muting cannot wrap into a timeout.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mst     <= MS_IDLE;
            pairMs  <= '0;
            msInSec <= '0;
            muteSec <= '0;
            outSeen <= 1'b0;
        end else begin
            mst <= next_mst;
            if (mst != MS_WAIT2) begin
                pairMs <= '0;
            end else if (msTick && !pairLate) begin
                pairMs <= pairMs + 13'h0001;
            end
            if (!muted) begin
                msInSec <= '0;
                muteSec <= '0;
                outSeen <= 1'b0;
            end else begin
                if (muteSensOut) begin
                    outSeen <= 1'b1;
                end
                if (msTick) begin
                    msInSec <= secWrap ? '0 : msInSec + 10'h001;
                end
                if (secWrap && (muteSec != 16'hFFFF)) begin
                    muteSec <= muteSec + 16'h0001;
                end
            end
        end
    end

    // Registered outputs.
    mzs_pkg::mzs_stat_t stat;
    assign stat = '{zoneSet: zoneSet, zoneFault: zoneFault, muted: muted,
                    cancelled: inCancel, winRunning: winRunning};

    logic [31:0] rdMux;
    always_comb begin
        case (regAddr)
            mzs_pkg::ADDR_CTRL:   rdMux = {18'h00000, cfg.dust, 3'h0, cfg.unlimited,
                                           3'h0, cfg.winSteps};
            mzs_pkg::ADDR_LIMIT:  rdMux = {16'h0000, limitS};
            mzs_pkg::ADDR_STATE:  rdMux = {21'h000000, mst, $bits(stat)'(stat)};
            mzs_pkg::ADDR_IRQ_ST: rdMux = {27'h0000000, irqStat};
            mzs_pkg::ADDR_IRQ_MK: rdMux = {27'h0000000, irqMask};
            default:              rdMux = 32'h00000000;
        endcase
    end

    // Read data are zero outside the read slot, so a stale value is never taken as an answer.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            regRdata               <= 32'h00000000;
            activeZone             <= '0;
            safetySwitchOutputPair <= 2'h0;
            muteLamp               <= 1'b0;
            dustLevel              <= 2'h0;
            irq                    <= 1'b0;
        end else begin
            regRdata               <= regRd ? rdMux : 32'h00000000;
            activeZone             <= zoneSet;
            safetySwitchOutputPair <= {2{pairOn}};
            muteLamp               <= (next_mst == MS_MUTED) && flash;
            dustLevel              <= cfg.dust;
            irq                    <= |(irqStat & irqMask);
        end
    end

endmodule // mzs_muting_zone

`default_nettype wire

// >>> verification/mzs_muting_zone_properties.sv
`timescale 1ns/10ps
`default_nettype none

module mzs_muting_zone_checker #(
    parameter int ZONE_SETS = 10
) (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic [3:0]  zoneCode,
    input wire logic        muteSensA,
    input wire logic        muteSensB,
    input wire logic        muteSensOut,
    input wire logic        objectInZone,
    input wire logic [3:0]  activeZone,
    input wire logic [1:0]  safetySwitchOutputPair,
    input wire logic        muteLamp,
    input wire logic [1:0]  dustLevel,
    input wire logic        irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_rst;
        disable iff (1'b0) sys_rst |=> safetySwitchOutputPair == 2'b00 && !muteLamp && !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not safe after reset");
    property p_rdIdle;
        !regRd |=> regRdata == 32'h0;
    endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
    property p_violation;
        (objectInZone && !muteSensA && !muteSensB && !muteSensOut) [*2]
            |=> safetySwitchOutputPair == 2'b00;
    endproperty
    a_violation: assert property (p_violation) else $error("pair on despite object");
    property p_lampDark;
        (!muteSensA && !muteSensB && !muteSensOut) [*2] |=> !muteLamp;
    endproperty
    a_lampDark: assert property (p_lampDark) else $error("lamp on without muting");
    property p_pairAgree;
        safetySwitchOutputPair[0] == safetySwitchOutputPair[1];
    endproperty
    a_pairAgree: assert property (p_pairAgree) else $error("pair bits disagree");
    property p_dust;
        dustLevel != 2'h3;
    endproperty
    a_dust: assert property (p_dust) else $error("undefined dust level");
    property p_zone;
        (!sys_rst && $stable(zoneCode) && zoneCode < ZONE_SETS) [*3] |-> activeZone == zoneCode;
    endproperty
    a_zone: assert property (p_zone) else $error("valid zone code not taken");
    property p_irqMask;
        regWr && regAddr == mzs_pkg::ADDR_IRQ_MK && regWdata[4:0] == 5'h00 |=> ##1 !irq;
    endproperty
    a_irqMask: assert property (p_irqMask) else $error("masked interrupt still high");

    c_mute: cover property ($rose(muteLamp));
    c_safe: cover property ($fell(safetySwitchOutputPair[0]));
    c_irq: cover property ($rose(irq));
endmodule // mzs_muting_zone_checker

bind mzs_muting_zone mzs_muting_zone_checker #(.ZONE_SETS(ZONE_SETS)) chk_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .zoneCode(zoneCode),
    .muteSensA(muteSensA), .muteSensB(muteSensB), .muteSensOut(muteSensOut),
    .objectInZone(objectInZone), .activeZone(activeZone),
    .safetySwitchOutputPair(safetySwitchOutputPair), .muteLamp(muteLamp),
    .dustLevel(dustLevel), .irq(irq)
);
`default_nettype wire

// >>> verification/mzs_field_model.sv
`timescale 1ns/10ps
`default_nettype none

module mzs_field_model (
    // Clock
    input  wire logic core_clk,
    // Conveyor sensors
    output logic      muteSensA,
    output logic      muteSensB,
    output logic      muteSensOut
);
    initial begin
        muteSensA = 1'b0;
        muteSensB = 1'b0;
        muteSensOut = 1'b0;
    end
    // Material reaches the first sensor, then the second after gap cycles.
    task automatic feed(input int gap);
        muteSensA <= 1'b1;
        repeat (gap) @(posedge core_clk);
        muteSensB <= 1'b1;
    endtask
    task automatic leave();
        muteSensOut <= 1'b1;
        repeat (20) @(posedge core_clk);
        muteSensA <= 1'b0;
        muteSensB <= 1'b0;
        repeat (20) @(posedge core_clk);
        muteSensOut <= 1'b0;
    endtask
    task automatic clear();
        muteSensA <= 1'b0;
        muteSensB <= 1'b0;
        muteSensOut <= 1'b0;
    endtask
endmodule // mzs_field_model
`default_nettype wire

// >>> verification/muting_and_zone_switch_control_test.sv
`timescale 1ns/10ps
`default_nettype none

module muting_and_zone_switch_control_test;
    logic core_clk, sys_rst, regWr, regRd, objectInZone, muteLamp, irq;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata;
    logic [3:0]  zoneCode, activeZone;
    logic [1:0]  pair, dustLevel;
    logic        sA, sB, sOut;
    int          failures = 0, check_count = 0, cycles = 0;

    mzs_muting_zone #(.CYC_PER_MS(4)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .zoneCode(zoneCode),
        .muteSensA(sA), .muteSensB(sB), .muteSensOut(sOut), .objectInZone(objectInZone),
        .activeZone(activeZone), .safetySwitchOutputPair(pair), .muteLamp(muteLamp),
        .dustLevel(dustLevel), .irq(irq)
    );
    mzs_field_model fields_u (.core_clk(core_clk), .muteSensA(sA), .muteSensB(sB),
        .muteSensOut(sOut));

    always #20 core_clk = ~core_clk;

    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        cyc(1);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        cyc(1);
        regRd <= 1'b0;
        #1 chk(regRdata, e);
        cyc(1);
    endtask
    // Watches the lamp for n cycles and compares whether it ever lit.
    task automatic lampSeen(input int n, input logic e);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            cyc(1);
            seen = seen | muteLamp;
        end
        chk(seen, e);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        zoneCode = 4'h3;
        objectInZone = 1'b0;
        cyc(6);
        sys_rst <= 1'b0;
        cyc(3);
        chk(pair, 2'b11);
        rd(mzs_pkg::ADDR_CTRL, 32'h0000_1001);
        rd(mzs_pkg::ADDR_LIMIT, 32'(mzs_pkg::MUTE_LIMIT_S));
        rd(8'h14, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(mzs_pkg::ADDR_CTRL, 32'h1 | (i << 12));
            cyc(2);
            chk(dustLevel, (i == 3) ? 2 : i);
        end
        // Window of 2 steps is 240 cycles at 4 cycles per millisecond.
        wr(mzs_pkg::ADDR_CTRL, 32'h0000_1002);
        zoneCode <= 4'hF;
        cyc(200);
        chk(pair, 2'b11);
        zoneCode <= 4'h5;
        cyc(3);
        chk(activeZone, 4'h5);
        zoneCode <= 4'hF;
        cyc(250);
        chk(pair, 2'b00);
        zoneCode <= 4'h3;
        cyc(3);
        chk(pair, 2'b11);
        // Every valid zone code is taken; the first invalid one keeps the last valid set.
        for (int z = 0; z < 11; z++) begin
            zoneCode <= 4'(z);
            cyc(3);
            chk(activeZone, (z < 10) ? z : 9);
            chk(pair, 2'b11);
        end
        zoneCode <= 4'h3;
        cyc(3);
        wr(mzs_pkg::ADDR_IRQ_MK, 32'h1F);
        fork
            fields_u.feed(100);
            lampSeen(95, 1'b0);
        join
        lampSeen(2100, 1'b1);
        chk(irq, 1'b1);
        objectInZone <= 1'b1;
        cyc(5);
        chk(pair, 2'b11);
        objectInZone <= 1'b0;
        fields_u.leave();
        cyc(3);
        chk(muteLamp, 1'b0);
        wr(mzs_pkg::ADDR_IRQ_ST, 32'h1F);
        cyc(2);
        chk(irq, 1'b0);
        rd(mzs_pkg::ADDR_IRQ_ST, 32'h0);
        fields_u.feed(16100);
        lampSeen(2100, 1'b0);
        fields_u.clear();
        cyc(3);
        objectInZone <= 1'b1;
        fields_u.feed(0);
        lampSeen(2100, 1'b0);
        fields_u.clear();
        objectInZone <= 1'b0;
        cyc(3);
        // A one second limit is 4000 cycles here.
        wr(mzs_pkg::ADDR_LIMIT, 32'h1);
        fields_u.feed(0);
        lampSeen(2100, 1'b1);
        cyc(2100);
        chk(pair, 2'b00);
        chk(muteLamp, 1'b0);
        rd(mzs_pkg::ADDR_STATE, 32'h0000_0332);
        fields_u.clear();
        cyc(3);
        wr(mzs_pkg::ADDR_CTRL, 32'h0000_1102);
        fields_u.feed(0);
        cyc(5000);
        chk(pair, 2'b11);
        lampSeen(2100, 1'b1);
        fields_u.clear();
        cyc(4);
        chk(muteLamp, 1'b0);
        rd(mzs_pkg::ADDR_IRQ_ST, 32'h0000_0007);
        chk(irq, 1'b1);
        wr(mzs_pkg::ADDR_IRQ_MK, 32'h0);
        cyc(2);
        chk(irq, 1'b0);
        // A second reset in mid-run must drop the pair and restore the defaults.
        sys_rst <= 1'b1;
        cyc(2);
        chk(pair, 2'b00);
        sys_rst <= 1'b0;
        cyc(3);
        chk(pair, 2'b11);
        rd(mzs_pkg::ADDR_CTRL, 32'h0000_1001);
        rd(mzs_pkg::ADDR_LIMIT, 32'(mzs_pkg::MUTE_LIMIT_S));
        finish_test();
    end
endmodule // muting_and_zone_switch_control_test
`default_nettype wire
